// ### rtl/valve_position_monitor.sv
`default_nettype none
module valve_position_monitor #(
  parameter int unsigned MS_TICK_CYCLES = valve_monitor_pkg::MS_CYCLES,
  parameter int unsigned BLINK_STEP     = valve_monitor_pkg::BLINK_CYCLES
) (
  // clock and reset
  input  wire logic                                   clk_i,
  input  wire logic                                   reset_n_i,
  // host configuration
  input  wire valve_monitor_pkg::config_t             cfg_i,
  input  wire logic                                   cfg_defaults_i,
  input  wire logic                                   calib_active_i,
  // sensor pins
  input  wire valve_monitor_pkg::pos_t                command_i,
  input  wire valve_monitor_pkg::pos_t                position_i,
  input  wire valve_monitor_pkg::press_set_t          press_i,
  // spool drive
  output valve_monitor_pkg::pos_t                     spool_target_o,
  output logic                                        sat_closed_o,
  output logic                                        sat_open_o,
  output logic                                        tight_shutoff_o,
  // diagnostics
  output valve_monitor_pkg::alarm_t                   alarm_o,
  output logic [valve_monitor_pkg::TRAVEL_W-1:0]      travel_total_o,
  output logic [valve_monitor_pkg::COUNT_W-1:0]       cycle_count_o,
  output valve_monitor_pkg::led_color_t               led_color_o
);
  import valve_monitor_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic       rst_meta_reg;
  logic       rst_n;
  pos_t       cmd_meta_reg, cmd_reg, pos_meta_reg, pos_reg;
  press_set_t press_meta_reg, press_reg;
  logic       calib_meta_reg, calib_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // multi-bit samples: sensors change slowly against the 50 MHz clock
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_meta_reg   <= 16'sh0;
      cmd_reg        <= 16'sh0;
      pos_meta_reg   <= 16'sh0;
      pos_reg        <= 16'sh0;
      press_meta_reg <= '0;
      press_reg      <= '0;
      calib_meta_reg <= 1'b0;
      calib_reg      <= 1'b0;
    end else begin
      cmd_meta_reg   <= command_i;
      cmd_reg        <= cmd_meta_reg;
      pos_meta_reg   <= position_i;
      pos_reg        <= pos_meta_reg;
      press_meta_reg <= press_i;
      press_reg      <= press_meta_reg;
      calib_meta_reg <= calib_active_i;
      calib_reg      <= calib_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // effective configuration; alert limits and travel dead band take defaults while cfg_defaults_i is high
  pos_t alert_lo, alert_hi, travel_band;
  always_comb begin
    alert_lo    = cfg_defaults_i ? ALERT_LO_RESET : cfg_i.alert_lo;
    alert_hi    = cfg_defaults_i ? ALERT_HI_RESET : cfg_i.alert_hi;
    travel_band = cfg_defaults_i ? DEADBAND_RESET : cfg_i.travel_deadband;
  end

  logic soft_stops_on, lo_cut_allowed, hi_cut_allowed;
  always_comb begin
    soft_stops_on  = (cfg_i.lower_travel_clamp > ZERO_SCALE) ||
                     (cfg_i.upper_travel_clamp < FULL_SCALE);
    lo_cut_allowed = !soft_stops_on && (cfg_i.lower_travel_clamp <= ZERO_SCALE);
    hi_cut_allowed = !soft_stops_on;
  end

  //////////////////////////////////////////////////////////////////////////
  // tight shutoff with hysteresis
  logic sat_lo_reg, sat_hi_reg;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sat_lo_reg <= 1'b0;
    end else if (!lo_cut_allowed) begin
      sat_lo_reg <= 1'b0;
    end else if (!sat_lo_reg) begin
      sat_lo_reg <= (cmd_reg <= cfg_i.low_shutoff_threshold);
    end else begin
      sat_lo_reg <= (cmd_reg < 16'(cfg_i.low_shutoff_threshold + HYSTERESIS));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sat_hi_reg <= 1'b0;
    end else if (!hi_cut_allowed) begin
      sat_hi_reg <= 1'b0;
    end else if (!sat_hi_reg) begin
      sat_hi_reg <= (cmd_reg >= cfg_i.high_shutoff_threshold);
    end else begin
      sat_hi_reg <= (cmd_reg > 16'(cfg_i.high_shutoff_threshold - HYSTERESIS));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // spool target: saturation first, then soft clamps
  logic clamp_lo, clamp_hi;
  always_comb begin
    clamp_lo = soft_stops_on && (cmd_reg < cfg_i.lower_travel_clamp);
    clamp_hi = soft_stops_on && (cmd_reg > cfg_i.upper_travel_clamp);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      spool_target_o  <= 16'sh0;
      sat_closed_o    <= 1'b0;
      sat_open_o      <= 1'b0;
      tight_shutoff_o <= 1'b0;
    end else begin
      sat_closed_o    <= sat_lo_reg;
      sat_open_o      <= sat_hi_reg;
      tight_shutoff_o <= sat_lo_reg || sat_hi_reg;
      if (sat_lo_reg) begin
        spool_target_o <= ZERO_SCALE;
      end else if (sat_hi_reg) begin
        spool_target_o <= FULL_SCALE;
      end else if (clamp_lo) begin
        spool_target_o <= cfg_i.lower_travel_clamp;
      end else if (clamp_hi) begin
        spool_target_o <= cfg_i.upper_travel_clamp;
      end else begin
        spool_target_o <= cmd_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pressure alarms
  logic press_loss_reg, top_alarm_reg, bot_alarm_reg, calib_prev_reg;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      press_loss_reg <= 1'b0;
    end else begin
      press_loss_reg <= (press_reg.supply < 16'(PRESS_MIN_OPER + PRESS_NEAR_BAND));
    end
  end

  // sensor alarms persist until the next calibration starts; a bad reading wins
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      top_alarm_reg  <= 1'b0;
      bot_alarm_reg  <= 1'b0;
      calib_prev_reg <= 1'b0;
    end else begin
      calib_prev_reg <= calib_reg;
      if (calib_reg && ((press_reg.top < cfg_i.sensor_min) || (press_reg.top > cfg_i.sensor_max))) begin
        top_alarm_reg <= 1'b1;
      end else if (calib_reg && !calib_prev_reg) begin
        top_alarm_reg <= 1'b0;
      end
      if (calib_reg && ((press_reg.bottom < cfg_i.sensor_min) || (press_reg.bottom > cfg_i.sensor_max))) begin
        bot_alarm_reg <= 1'b1;
      end else if (calib_reg && !calib_prev_reg) begin
        bot_alarm_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // travel accumulator
  logic                started_reg;
  logic [1:0]          warm_reg;
  pos_t                centre_reg;
  logic [TRAVEL_W-1:0] travel_reg;
  logic [16:0]         travel_dist;
  logic [32:0]         travel_step;
  logic [TRAVEL_W:0]   travel_sum;
  logic                out_of_band;

  always_comb begin
    travel_dist = abs_diff(pos_reg, centre_reg);
    travel_step = travel_dist * cfg_i.stroke_len;
    travel_sum  = {1'b0, travel_reg} + (TRAVEL_W + 1)'(travel_step);
    out_of_band = (travel_dist >= {1'b0, travel_band});
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      started_reg <= 1'b0;
      warm_reg    <= 2'h0;
      centre_reg  <= 16'sh0;
      travel_reg  <= '0;
    end else if (!started_reg) begin
      // wait for the position synchroniser to fill, else the centre is zero
      warm_reg <= warm_reg + 2'h1;
      if (warm_reg == 2'h2) begin
        started_reg <= 1'b1;
        centre_reg  <= pos_reg;
      end
    end else if (out_of_band) begin
      travel_reg <= travel_sum[TRAVEL_W] ? '1 : travel_sum[TRAVEL_W-1:0];
      centre_reg <= pos_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // cycle counter
  pos_t               cyc_ref_reg;
  logic               dir_up_reg, dir_known_reg;
  logic [COUNT_W-1:0] cycles_reg;
  logic               cyc_moved, cyc_up;

  always_comb begin
    cyc_moved = abs_diff(pos_reg, cyc_ref_reg) > {1'b0, cfg_i.cycle_deadband};
    cyc_up    = pos_reg > cyc_ref_reg;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cyc_ref_reg   <= 16'sh0;
      dir_up_reg    <= 1'b0;
      dir_known_reg <= 1'b0;
      cycles_reg    <= '0;
    end else if (!started_reg) begin
      cyc_ref_reg <= pos_reg;
    end else if (cyc_moved) begin
      cyc_ref_reg   <= pos_reg;
      dir_up_reg    <= cyc_up;
      dir_known_reg <= 1'b1;
      if (dir_known_reg && (cyc_up != dir_up_reg) && (cycles_reg != '1)) begin
        cycles_reg <= cycles_reg + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // position deviation timer
  logic [31:0] ms_cnt_reg;
  logic [15:0] dev_ms_reg;
  logic        dev_alarm_reg;
  logic        deviating;

  assign deviating = abs_diff(pos_reg, spool_target_o) > {1'b0, cfg_i.dev_trip};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_reg    <= 32'h0;
      dev_ms_reg    <= 16'h0;
      dev_alarm_reg <= 1'b0;
    end else if (!deviating) begin
      ms_cnt_reg    <= 32'h0;
      dev_ms_reg    <= 16'h0;
      dev_alarm_reg <= 1'b0;
    end else begin
      if (dev_ms_reg >= cfg_i.dev_settle_ms) begin
        dev_alarm_reg <= 1'b1;
      end
      if (ms_cnt_reg == 32'(MS_TICK_CYCLES - 1)) begin
        ms_cnt_reg <= 32'h0;
        if (dev_ms_reg != 16'hffff) begin
          dev_ms_reg <= dev_ms_reg + 16'h1;
        end
      end else begin
        ms_cnt_reg <= ms_cnt_reg + 32'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // alarm outputs and blink code choice
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alarm_o        <= '0;
      travel_total_o <= '0;
      cycle_count_o  <= '0;
    end else begin
      alarm_o.press_loss    <= press_loss_reg;
      alarm_o.top_sensor    <= top_alarm_reg;
      alarm_o.bottom_sensor <= bot_alarm_reg;
      alarm_o.cycle_limit   <= cycles_reg > cfg_i.cycle_limit;
      alarm_o.deviation     <= dev_alarm_reg;
      alarm_o.alert_lo      <= pos_reg < alert_lo;
      alarm_o.alert_hi      <= pos_reg > alert_hi;
      alarm_o.clamp_lo      <= clamp_lo && !sat_lo_reg && !sat_hi_reg;
      alarm_o.clamp_hi      <= clamp_hi && !sat_lo_reg && !sat_hi_reg;
      travel_total_o        <= travel_reg;
      cycle_count_o         <= cycles_reg;
    end
  end

  // most severe condition owns the lamp
  logic       code_valid;
  logic [7:0] code_sel;
  always_comb begin
    code_valid = 1'b1;
    if (alarm_o.deviation) begin
      code_sel = CODE_DEVIATION;
    end else if (alarm_o.press_loss) begin
      code_sel = CODE_PRESS_LOSS;
    end else if (alarm_o.cycle_limit) begin
      code_sel = CODE_CYCLES;
    end else if (alarm_o.clamp_lo || alarm_o.clamp_hi) begin
      code_sel = CODE_SOFT_LIMIT;
    end else if (alarm_o.alert_lo || alarm_o.alert_hi) begin
      code_sel = CODE_POS_ALERT;
    end else begin
      code_sel   = 8'h00;
      code_valid = 1'b0;
    end
  end

  led_sequencer #(
    .STEP_CYCLES (BLINK_STEP)
  ) u_led (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n),
    .code_valid_i (code_valid),
    .code_i       (code_sel),
    .led_color_o  (led_color_o)
  );

  //////////////////////////////////////////////////////////////////////////
  // checks
  chk_low_cut_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
    sat_lo_reg && lo_cut_allowed && (cmd_reg < 16'(cfg_i.low_shutoff_threshold + HYSTERESIS)) |=> sat_lo_reg)
    else $error("low saturation released below threshold plus hysteresis");

  chk_low_cut_set: assert property (@(posedge clk_i) disable iff (!rst_n)
    lo_cut_allowed && (cmd_reg <= cfg_i.low_shutoff_threshold) |=> sat_lo_reg ##1 sat_closed_o)
    else $error("low cutoff did not saturate closed");

  chk_soft_stop_off: assert property (@(posedge clk_i) disable iff (!rst_n)
    soft_stops_on |=> !sat_lo_reg && !sat_hi_reg)
    else $error("cutoff active while soft stops set");

  chk_clamp_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
    clamp_lo && !sat_lo_reg && !sat_hi_reg |=> spool_target_o == $past(cfg_i.lower_travel_clamp))
    else $error("stem target not held at lower clamp");

  chk_band_idle: assert property (@(posedge clk_i) disable iff (!rst_n)
    started_reg && !out_of_band |=> $stable(travel_reg))
    else $error("accumulator moved inside dead band");

  chk_band_recentre: assert property (@(posedge clk_i) disable iff (!rst_n)
    started_reg && out_of_band |=> centre_reg == $past(pos_reg))
    else $error("dead band not recentred after accumulation");

  chk_cycle_step: assert property (@(posedge clk_i) disable iff (!rst_n)
    cycles_reg != $past(cycles_reg) |-> $past(cyc_moved) && $past(dir_known_reg) && ($past(cyc_up) != $past(dir_up_reg)))
    else $error("cycle counted without band and reversal");

  chk_no_wrap: assert property (@(posedge clk_i) disable iff (!rst_n)
    (travel_reg == '1) |=> (travel_reg == '1))
    else $error("travel accumulator wrapped");

  chk_press_loss: assert property (@(posedge clk_i) disable iff (!rst_n)
    (press_reg.supply < 16'(PRESS_MIN_OPER + PRESS_NEAR_BAND)) |=> ##1 alarm_o.press_loss)
    else $error("low supply did not raise loss alarm");

endmodule // valve_position_monitor
`default_nettype wire

// ### rtl/valve_monitor_pkg.sv
`default_nettype none
package valve_monitor_pkg;

  // positions and commands in 0.01 percent of stroke, signed
  typedef logic signed [15:0] pos_t;
  typedef logic [15:0]        press_t;   // 0.1 psig units

  localparam pos_t   FULL_SCALE       = 16'sd10000;
  localparam pos_t   ZERO_SCALE       = 16'sd0;
  localparam pos_t   HYSTERESIS       = 16'sd100;     // 1 percent
  localparam pos_t   ALERT_LO_RESET   = -16'sd1000;   // -10 percent
  localparam pos_t   ALERT_HI_RESET   = 16'sd11000;   // 110 percent
  localparam pos_t   DEADBAND_RESET   = 16'sd2000;    // 20 percent
  localparam press_t PRESS_MIN_OPER   = 16'd300;      // 30 psig
  localparam press_t PRESS_NEAR_BAND  = 16'd20;       // 2 psig warning margin

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned BLINK_STEP_MS = 250;
  localparam int unsigned BLINK_CYCLES  = BLINK_STEP_MS * MS_CYCLES;

  localparam int TRAVEL_W = 48;
  localparam int COUNT_W  = 32;

  typedef enum logic [1:0] {
    LED_OFF    = 2'b00,
    LED_GREEN  = 2'b01,
    LED_RED    = 2'b10,
    LED_YELLOW = 2'b11
  } led_color_t;

  // four colours, first shown in the top two bits
  localparam logic [7:0] CODE_PRESS_LOSS = {LED_RED, LED_YELLOW, LED_YELLOW, LED_GREEN};
  localparam logic [7:0] CODE_CYCLES     = {LED_GREEN, LED_RED, LED_GREEN, LED_GREEN};
  localparam logic [7:0] CODE_DEVIATION  = {LED_RED, LED_RED, LED_RED, LED_RED};
  localparam logic [7:0] CODE_SOFT_LIMIT = {LED_GREEN, LED_YELLOW, LED_GREEN, LED_YELLOW};
  localparam logic [7:0] CODE_POS_ALERT  = {LED_GREEN, LED_YELLOW, LED_GREEN, LED_GREEN};

  typedef struct packed {
    pos_t               low_shutoff_threshold;
    pos_t               high_shutoff_threshold;
    pos_t               lower_travel_clamp;
    pos_t               upper_travel_clamp;
    pos_t               alert_lo;
    pos_t               alert_hi;
    pos_t               travel_deadband;
    pos_t               cycle_deadband;
    logic [15:0]        stroke_len;        // 0.001 inch units
    logic [COUNT_W-1:0] cycle_limit;
    pos_t               dev_trip;
    logic [15:0]        dev_settle_ms;
    press_t             sensor_min;
    press_t             sensor_max;
  } config_t;

  typedef struct packed {
    press_t supply;
    press_t top;
    press_t bottom;
  } press_set_t;

  typedef struct packed {
    logic press_loss;
    logic top_sensor;
    logic bottom_sensor;
    logic cycle_limit;
    logic deviation;
    logic alert_lo;
    logic alert_hi;
    logic clamp_lo;
    logic clamp_hi;
  } alarm_t;

  function automatic logic [16:0] abs_diff(input pos_t a, input pos_t b);
    logic signed [16:0] d;
    d = {a[15], a} - {b[15], b};
    abs_diff = d[16] ? 17'(-d) : 17'(d);
  endfunction

endpackage
`default_nettype wire

// ### rtl/led_sequencer.sv
`default_nettype none
module led_sequencer #(
  parameter int unsigned STEP_CYCLES = 12500000
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_n_i,
  // code request
  input  wire logic                           code_valid_i,
  input  wire logic [7:0]                     code_i,
  // lamp
  output var valve_monitor_pkg::led_color_t   led_color_o
);
  import valve_monitor_pkg::*;

  logic [31:0] step_cnt_reg;
  logic [2:0]  slot_reg;      // 0..3 colours, 4 dark gap
  logic [7:0]  code_reg;
  logic        run_reg;

  //////////////////////////////////////////////////////////////////////////
  // a code is latched for a whole sequence so colours never mix mid-blink
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_cnt_reg <= 32'h0;
      slot_reg     <= 3'h0;
      code_reg     <= 8'h0;
      run_reg      <= 1'b0;
    end else if (!run_reg) begin
      if (code_valid_i) begin
        run_reg      <= 1'b1;
        code_reg     <= code_i;
        slot_reg     <= 3'h0;
        step_cnt_reg <= 32'h0;
      end
    end else if (step_cnt_reg == 32'(STEP_CYCLES - 1)) begin
      step_cnt_reg <= 32'h0;
      if (slot_reg == 3'h4) begin
        run_reg  <= 1'b0;
        slot_reg <= 3'h0;
      end else begin
        slot_reg <= slot_reg + 3'h1;
      end
    end else begin
      step_cnt_reg <= step_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_color_o <= LED_OFF;
    end else if (!run_reg || slot_reg == 3'h4) begin
      led_color_o <= LED_OFF;
    end else begin
      case (slot_reg)
        3'h0:    led_color_o <= led_color_t'(code_reg[7:6]);
        3'h1:    led_color_o <= led_color_t'(code_reg[5:4]);
        3'h2:    led_color_o <= led_color_t'(code_reg[3:2]);
        default: led_color_o <= led_color_t'(code_reg[1:0]);
      endcase
    end
  end

endmodule // led_sequencer
`default_nettype wire

// ### verif/actuator_model.sv
`default_nettype none
module actuator_model
  import valve_monitor_pkg::*;
(
  // clock
  input  wire logic clk_i,
  // control from bench
  input  wire logic follow_i,
  input  wire pos_t hold_pos_i,
  // spool drive from block
  input  wire pos_t spool_target_i,
  // stem feedback
  output var  pos_t position_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ideal stem: tracks the spool one clock later while follow_i is high, so any further lag comes from the block
  always_ff @(posedge clk_i) begin
    position_o <= follow_i ? spool_target_i : hold_pos_i;
  end
endmodule // actuator_model
`default_nettype wire

// ### verif/valve_position_monitor_bench.sv
`default_nettype none
module valve_position_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import valve_monitor_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, dflt = 1'b1, calib = 1'b0, follow = 1'b0;
  config_t cfg;
  pos_t cmd = 16'sd5000, hold = 16'sd5000, pos, spool;
  press_set_t press = '{16'd400, 16'd100, 16'd100};
  logic sat_c, sat_o, tso;
  alarm_t alm;
  logic [TRAVEL_W-1:0] travel;
  logic [COUNT_W-1:0] cycles;
  led_color_t led;
  int err_count = 0, tests_run = 0;
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    cfg = '{16'sd500, 16'sd9500, 16'sd0, 16'sd10000, -16'sd1000, 16'sd11000, 16'sd2000, 16'sd100,
            16'h0004, 32'h0000_ffff, 16'sd30000, 16'h0001, 16'h0000, 16'hffff};
  end
  actuator_model i_actuator_model (.clk_i(clk), .follow_i(follow), .hold_pos_i(hold),
    .spool_target_i(spool), .position_o(pos));
  valve_position_monitor #(.MS_TICK_CYCLES(10), .BLINK_STEP(4)) i_valve_position_monitor (
    .clk_i(clk), .reset_n_i(reset_n), .cfg_i(cfg), .cfg_defaults_i(dflt), .calib_active_i(calib),
    .command_i(cmd), .position_i(pos), .press_i(press), .spool_target_o(spool), .sat_closed_o(sat_c),
    .sat_open_o(sat_o), .tight_shutoff_o(tso), .alarm_o(alm), .travel_total_o(travel),
    .cycle_count_o(cycles), .led_color_o(led));
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_val(input string what, input logic [47:0] exp, input logic [47:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_travel;
    @(posedge clk) hold <= 16'sd6999;
    settle(8);
    chk_val("travel", 48'h0, travel);
    @(posedge clk) hold <= 16'sd8000;
    settle(8);
    chk_val("travel", 48'd12000, travel);
    @(posedge clk) hold <= 16'sd6001;
    settle(8);
    chk_val("travel", 48'd12000, travel);
    chk_val("cycles", 48'd1, 48'(cycles));
    $display("test travel done");
  endtask
  task automatic t_cutoff;
    @(posedge clk) cmd <= 16'sd500;
    settle(8);
    chk_val("sat_closed", 48'd1, 48'(sat_c));
    chk_val("spool", 48'd0, 48'(spool));
    @(posedge clk) cmd <= 16'sd599;
    settle(8);
    chk_val("sat_closed", 48'd1, 48'(sat_c));
    @(posedge clk) cmd <= 16'sd600;
    settle(8);
    chk_val("sat_closed", 48'd0, 48'(sat_c));
    @(posedge clk) cmd <= 16'sd9500;
    settle(8);
    chk_val("sat_open", 48'd1, 48'(sat_o));
    chk_val("spool", 48'd10000, 48'(spool));
    $display("test cutoff done");
  endtask
  task automatic t_soft;
    @(posedge clk) begin
      cfg.lower_travel_clamp <= 16'sd1000;
      cmd <= 16'sd200;
    end
    settle(8);
    chk_val("sat_closed", 48'd0, 48'(sat_c));
    chk_val("spool", 48'd1000, 48'(spool));
    chk_val("clamp_lo", 48'd1, 48'(alm.clamp_lo));
    @(posedge clk) cfg.lower_travel_clamp <= 16'sd0;
    $display("test soft limit done");
  endtask
  task automatic t_alert;
    @(posedge clk) begin
      cmd <= 16'sd5000;
      hold <= 16'sd10500;
    end
    settle(8);
    chk_val("alert_hi", 48'd0, 48'(alm.alert_hi));
    @(posedge clk) begin
      dflt <= 1'b0;
      cfg.alert_hi <= 16'sd8000;
    end
    settle(8);
    chk_val("alert_hi", 48'd1, 48'(alm.alert_hi));
    chk_val("spool", 48'd5000, 48'(spool));
    $display("test alert done");
  endtask
  task automatic t_press;
    @(posedge clk) press.supply <= 16'd319;
    settle(8);
    chk_val("press_loss", 48'd1, 48'(alm.press_loss));
    // loss code owns the lamp; wait for its first red, then step the slots
    for (int i = 0; i < 60 && led != LED_RED; i++) settle(1);
    chk_val("led", 48'(LED_RED), 48'(led));
    settle(4);
    chk_val("led", 48'(LED_YELLOW), 48'(led));
    settle(4);
    chk_val("led", 48'(LED_YELLOW), 48'(led));
    settle(4);
    chk_val("led", 48'(LED_GREEN), 48'(led));
    @(posedge clk) press.supply <= 16'd320;
    settle(8);
    chk_val("press_loss", 48'd0, 48'(alm.press_loss));
    $display("test pressure done");
  endtask
  task automatic t_diag;
    @(posedge clk) begin
      cfg.dev_trip <= 16'sd1000;
      cfg.cycle_limit <= 32'h1;
      cfg.sensor_max <= 16'd500;
      press.top <= 16'd600;
      calib <= 1'b1;
    end
    settle(30);
    chk_val("deviation", 48'd1, 48'(alm.deviation));
    chk_val("cycle_limit", 48'd1, 48'(alm.cycle_limit));
    chk_val("top_sensor", 48'd1, 48'(alm.top_sensor));
    chk_val("bottom_sensor", 48'd0, 48'(alm.bottom_sensor));
    @(posedge clk) hold <= 16'sd5000;
    settle(8);
    chk_val("deviation", 48'd0, 48'(alm.deviation));
    $display("test diagnostics done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    settle(8);
    t_travel();
    t_cutoff();
    t_soft();
    t_alert();
    t_press();
    t_diag();
    give_verdict();
  end
  // whole run is about 200 cycles; stop a hang well past that
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule // valve_position_monitor_bench
`default_nettype wire
